// file: kscan_matrix_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// passive switch matrix, one isolation diode per key
// ------------------------------------------------------------
module kscan_matrix_model
(
	// system
	input  wire logic        clk_i,
	// closed keys, index row*8+column
	input  wire logic [63:0] keys_i,
	// device pins
	input  wire logic [7:0]  scan_n_i,
	input  wire logic [7:0]  scan_oe_i,
	input  wire logic [7:0]  pullup_en_i,
	output logic      [7:0]  matrix_o
);
	logic       float_q = 1'b0;
	logic [7:0] pulled_low;

	// an open column with its pull-up off floats, so it never shows a steady level
	always @(posedge clk_i)
		float_q <= ~float_q;

	// diodes let a closed key pull only its column, only while its row drives low
	always_comb
	begin
		pulled_low = '0;
		for (int r = 0; r < 8; r++)
			for (int c = 0; c < 8; c++)
				if (keys_i[r*8+c] && scan_oe_i[r] && !scan_n_i[r])
					pulled_low[c] = 1'b1;
		for (int c = 0; c < 8; c++)
			matrix_o[c] = pulled_low[c] ? 1'b0 : (pullup_en_i[c] ? 1'b1 : float_q);
	end
endmodule

// file: kscan_pkg.sv
package kscan_pkg;

	// ------------------------------------------------------------
	// register byte offsets on the bus
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CONTROL_1     = 8'h00;
	localparam logic [7:0] OFS_PIN_FUNCTION  = 8'h04;
	localparam logic [7:0] OFS_COUNTER_TIME  = 8'h08;
	localparam logic [7:0] OFS_COUNTER_START = 8'h0c;
	localparam logic [7:0] OFS_SCAN_COUNTER  = 8'h10;
	localparam logic [7:0] OFS_SCAN_STATUS   = 8'h14;
	localparam logic [7:0] OFS_IRQ_ENABLE    = 8'h18;
	localparam logic [7:0] OFS_STANDBY_FLAGS = 8'h1c;
	localparam logic [7:0] OFS_SCAN_DATA_0   = 8'h20;
	localparam logic [7:0] OFS_SCAN_DATA_END = 8'h3c;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTL_FUNC_EN   = 0;
	localparam int CTL_SIZE_4X4  = 1;
	localparam int CTL_DATA_CLR  = 2;
	localparam int TIM_PULL_DBL  = 4;
	localparam int TIM_LOW_LEN   = 5;
	localparam int FLAG_MATRIX   = 2;

	// ------------------------------------------------------------
	// reset values and timing counts
	// ------------------------------------------------------------
	localparam logic [7:0] SCAN_DATA_INIT = 8'hff;
	localparam logic [7:0] PERIOD_LAST    = 8'h7f;
	localparam logic [7:0] PERIOD_LAST_X2 = 8'hff;
	localparam int         ROWS_SMALL     = 4;
	localparam int         ROWS_LARGE     = 8;
	// operating clock is the slow crystal input divided by two
	localparam int         OP_CLOCK_DIV   = 2;

endpackage

// file: kscan_top.sv
// Local design decisions: the Wishbone register port and the address map.
`timescale 1ns/1ps
// Overview of operation
// - select bit 1 gives 4x4, 0 gives 8x8
// - matrix runs only when enabled and pins selected
// - latch inputs into row register at pull-up end
// - four or eight scans per cycle into registers
// - changed row value sets matrix change flag
// - enabled matrix flag requests interrupt and wakeup
// - scanning continues after flag until counter stops
// - pull-up duration set by counter clock select
// - pull-up period 8..64 ms, doubled by bit
// - scan low for duration or whole period
// - interrupt while any enabled change flag set
// - interrupt in standby sets standby release flag
// - module standby halts block and register access
// - scanning continues after interrupt, data overwritten
// - deselected input reads 1, no pull-up, no output
// - disabled function makes pins read 1
// - writes take effect on operating clock tick (interrupt enable, flag-clear and standby-flag-clear writes act at once here)
// - data clear bit holds data registers initial
// - only scanned output low, others high
// - counter clock is crystal divided by 2..16
// - counter counts while started, clears at period
module kscan_top
(
	// system
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// classic wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// power management
	input  wire logic        module_stop_i,
	input  wire logic        soft_standby_i,
	output logic             osc_enable_o,
	output logic             wake_o,
	// key input change events from the plain key-input logic
	input  wire logic [1:0]  key_change_i,
	// slow crystal input and matrix pins
	input  wire logic        slow_crystal_input_i,
	input  wire logic [7:0]  matrix_in_i,
	output logic      [7:0]  pullup_en_o,
	output logic      [7:0]  scan_output_pins_n_o,
	output logic      [7:0]  scan_output_pins_oe_o,
	// interrupt
	output logic             scan_interrupt_o
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// counter clock prescale mask for divide by 2, 4, 8 or 16
	function automatic logic [3:0] div_mask(input logic [1:0] sel);
		div_mask = (sel == 2'b00) ? 4'h1 : (sel == 2'b01) ? 4'h3 :
		           (sel == 2'b10) ? 4'h7 : 4'hf;
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic        clr;
	logic        xtal_s1, xtal_s2, xtal_s3;
	logic [7:0]  in_s1, in_s2;
	logic [3:0]  prescale;
	// bus-side copies, updated at once by bus accesses
	logic [2:0]  control_1;
	logic [15:0] pin_function_control;
	logic [5:0]  counter_timing_control;
	logic        counter_start_reg;
	logic [2:0]  scan_status;
	logic [2:0]  scan_irq_enable_reg;
	logic        standby_release_flag;
	logic [2:0]  flag_seen;
	// copies the scan logic uses, taken on the operating clock tick
	logic [2:0]  act_ctrl;
	logic [15:0] act_pins;
	logic [5:0]  act_timing;
	logic        counter_run;
	logic [7:0]  scan_counter;
	logic [2:0]  row;
	logic [7:0]  scan_data [0:7];

	// module standby initialises the block as reset does, except the bus ack and read data
	assign clr          = rst_i | module_stop_i;
	assign osc_enable_o = ~module_stop_i;

	// ------------------------------------------------------------
	// slow clock recovery
	// ------------------------------------------------------------
	logic xtal_rise, op_tick, cnt_tick;
	assign xtal_rise = xtal_s2 & ~xtal_s3;
	assign op_tick   = xtal_rise & prescale[0];
	assign cnt_tick  = xtal_rise & ((prescale & div_mask(act_timing[1:0]))
	                   == div_mask(act_timing[1:0]));

	// crystal and pin synchronisers, prescaler on crystal rising edges
	always_ff @(posedge clk_i)
	begin
		xtal_s1 <= slow_crystal_input_i;
		xtal_s2 <= xtal_s1;
		xtal_s3 <= xtal_s2;
		in_s1   <= matrix_in_i;
		in_s2   <= in_s1;
		if (clr)
			prescale <= 4'h0;
		else if (xtal_rise)
			prescale <= prescale + 4'h1;
	end

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	logic bus_req, bus_wr, bus_rd, bus_open, data_hit;
	logic [2:0] data_idx;
	assign bus_req  = cyc_i & stb_i;
	// standby keeps the bus answering, but access has no effect
	assign bus_open = bus_req & ack_o & ~module_stop_i;
	assign bus_wr   = bus_open & we_i & sel_i[0];
	assign bus_rd   = bus_open & ~we_i;
	assign data_hit = (adr_i >= kscan_pkg::OFS_SCAN_DATA_0) &&
	                  (adr_i <= kscan_pkg::OFS_SCAN_DATA_END);
	assign data_idx = adr_i[4:2];

	logic [7:0] rd_byte;
	// reads show the applied copies, so a read-back confirms a write
	assign rd_byte =
		(adr_i == kscan_pkg::OFS_CONTROL_1)     ? {5'h00, act_ctrl} :
		(adr_i == kscan_pkg::OFS_PIN_FUNCTION)  ? act_pins[7:0] :
		(adr_i == kscan_pkg::OFS_COUNTER_TIME)  ? {2'h0, act_timing} :
		(adr_i == kscan_pkg::OFS_COUNTER_START) ? {7'h00, counter_run} :
		(adr_i == kscan_pkg::OFS_SCAN_COUNTER)  ? scan_counter :
		(adr_i == kscan_pkg::OFS_SCAN_STATUS)   ? {5'h00, scan_status} :
		(adr_i == kscan_pkg::OFS_IRQ_ENABLE)    ? {5'h00, scan_irq_enable_reg} :
		(adr_i == kscan_pkg::OFS_STANDBY_FLAGS) ? {7'h00, standby_release_flag} :
		data_hit                                ? scan_data[data_idx] : 8'h00;
	logic [7:0] rd_hi;
	assign rd_hi = (adr_i == kscan_pkg::OFS_PIN_FUNCTION) ? act_pins[15:8] : 8'h00;

	// one wait state: ack one cycle after the strobe, dropped the cycle after
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end
		else
		begin
			ack_o <= bus_req & ~ack_o;
			dat_o <= (module_stop_i | we_i) ? 32'h0000_0000 : {16'h0000, rd_hi, rd_byte};
		end
	end

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	logic w_ctl, w_pin, w_tim, w_run, w_ien;
	assign w_ctl = bus_wr & (adr_i == kscan_pkg::OFS_CONTROL_1);
	assign w_pin = bus_wr & (adr_i == kscan_pkg::OFS_PIN_FUNCTION);
	assign w_tim = bus_wr & (adr_i == kscan_pkg::OFS_COUNTER_TIME);
	assign w_run = bus_wr & (adr_i == kscan_pkg::OFS_COUNTER_START);
	assign w_ien = bus_wr & (adr_i == kscan_pkg::OFS_IRQ_ENABLE);

	always_ff @(posedge clk_i)
	begin
		if (clr)
		begin
			control_1              <= 3'h0;
			pin_function_control   <= 16'h0000;
			counter_timing_control <= 6'h00;
			counter_start_reg      <= 1'b0;
			scan_irq_enable_reg    <= 3'h0;
		end
		else
		begin
			if (w_ctl)
				control_1 <= dat_i[2:0];
			if (w_pin & sel_i[1])
				pin_function_control <= dat_i[15:0];
			if (w_tim)
				counter_timing_control <= {dat_i[5:4], 2'b00, dat_i[1:0]};
			if (w_run)
				counter_start_reg <= dat_i[0];
			if (w_ien)
				scan_irq_enable_reg <= dat_i[2:0];
		end
	end

	// writes reach the scan logic only on the operating clock tick
	always_ff @(posedge clk_i)
	begin
		if (clr)
		begin
			act_ctrl    <= 3'h0;
			act_pins    <= 16'h0000;
			act_timing  <= 6'h00;
			counter_run <= 1'b0;
		end
		else if (op_tick)
		begin
			act_ctrl    <= control_1;
			act_pins    <= pin_function_control;
			act_timing  <= counter_timing_control;
			counter_run <= counter_start_reg;
		end
	end

	// ------------------------------------------------------------
	// scan counter and row sequencing
	// ------------------------------------------------------------
	logic       func_en, size_4x4, at_last, duration, latch;
	logic [2:0] last_row;
	logic [7:0] period_last, in_sel_eff, sample, out_sel_eff;
	assign func_en     = act_ctrl[kscan_pkg::CTL_FUNC_EN];
	assign size_4x4    = act_ctrl[kscan_pkg::CTL_SIZE_4X4];
	assign last_row    = size_4x4 ? 3'(kscan_pkg::ROWS_SMALL - 1) :
	                                3'(kscan_pkg::ROWS_LARGE - 1);
	// period is 128 counter clocks, or 256 with the doubling bit
	assign period_last = act_timing[kscan_pkg::TIM_PULL_DBL] ?
	                     kscan_pkg::PERIOD_LAST_X2 : kscan_pkg::PERIOD_LAST;
	assign at_last     = scan_counter == period_last;
	// pull-up duration is the first counter clock of each period
	assign duration    = counter_run & (scan_counter == 8'h00);
	assign latch       = duration & cnt_tick;
	// an unselected or disabled input, or a row bit past a 4x4 matrix, reads as 1
	assign in_sel_eff  = act_pins[7:0] & {8{func_en}} &
	                     (size_4x4 ? 8'h0f : 8'hff);
	assign sample      = in_s2 | ~in_sel_eff;
	assign out_sel_eff = act_pins[15:8] & {8{func_en}} &
	                     (size_4x4 ? 8'h0f : 8'hff);

	// counter runs while started; stopping clears it and the row pointer
	always_ff @(posedge clk_i)
	begin
		if (clr || !counter_run)
		begin
			scan_counter <= 8'h00;
			row          <= 3'h0;
		end
		else if (cnt_tick)
		begin
			scan_counter <= at_last ? 8'h00 : scan_counter + 8'h01;
			if (at_last)
				row <= (row >= last_row) ? 3'h0 : row + 3'h1;
		end
	end

	// ------------------------------------------------------------
	// scan data registers
	// ------------------------------------------------------------
	logic changed;
	assign changed = latch & ~act_ctrl[kscan_pkg::CTL_DATA_CLR] &
	                 (sample != scan_data[row]);

	// data keeps being overwritten after a change is flagged
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_data
			always_ff @(posedge clk_i)
			begin
				if (clr || act_ctrl[kscan_pkg::CTL_DATA_CLR])
					scan_data[gi] <= kscan_pkg::SCAN_DATA_INIT;
				else if (latch && row == 3'(gi))
					scan_data[gi] <= sample;
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// change flags, interrupt and standby release
	// ------------------------------------------------------------
	logic [2:0] flag_set, flag_clr;
	logic       rd_status;
	assign rd_status = bus_rd & (adr_i == kscan_pkg::OFS_SCAN_STATUS);
	assign flag_set  = {changed, key_change_i};
	// a flag clears by writing 0 after it was read as 1; a new event wins
	assign flag_clr  = {3{bus_wr & (adr_i == kscan_pkg::OFS_SCAN_STATUS)}} &
	                   ~dat_i[2:0] & flag_seen;

	always_ff @(posedge clk_i)
	begin
		if (clr)
		begin
			scan_status <= 3'h0;
			flag_seen   <= 3'h0;
		end
		else
		begin
			scan_status <= flag_set | (scan_status & ~flag_clr);
			if (rd_status)
				flag_seen <= scan_status;
			else
				flag_seen <= flag_seen & ~flag_clr;
		end
	end

	// irq follows the flags, so clearing the flag withdraws it
	assign scan_interrupt_o = |(scan_status & scan_irq_enable_reg);
	assign wake_o           = scan_interrupt_o;

	logic w_sby;
	assign w_sby = bus_wr & (adr_i == kscan_pkg::OFS_STANDBY_FLAGS) & ~dat_i[0];
	always_ff @(posedge clk_i)
	begin
		if (clr)
			standby_release_flag <= 1'b0;
		else if (soft_standby_i & scan_interrupt_o)
			standby_release_flag <= 1'b1;
		else if (w_sby)
			standby_release_flag <= 1'b0;
	end

	// ------------------------------------------------------------
	// pin drive
	// ------------------------------------------------------------
	logic       low_window;
	logic [7:0] row_onehot;
	// low for the pull-up duration or for the whole period
	assign low_window = act_timing[kscan_pkg::TIM_LOW_LEN] ? counter_run : duration;
	assign row_onehot = 8'h01 << row;

	// registered so the pins never glitch between two rows
	always_ff @(posedge clk_i)
	begin
		if (clr)
		begin
			scan_output_pins_n_o  <= 8'hff;
			scan_output_pins_oe_o <= 8'h00;
			pullup_en_o           <= 8'h00;
		end
		else
		begin
			scan_output_pins_n_o  <= ~(row_onehot & out_sel_eff & {8{low_window}});
			scan_output_pins_oe_o <= out_sel_eff;
			pullup_en_o           <= in_sel_eff & {8{duration}};
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");

	a_change_flag: assert property (@(posedge clk_i) disable iff (clr)
		changed |=> scan_status[kscan_pkg::FLAG_MATRIX])
		else $error("row change did not set the matrix flag");

	a_irq_raised: assert property (@(posedge clk_i) disable iff (clr)
		scan_status[2] && scan_irq_enable_reg[2] |-> scan_interrupt_o && wake_o)
		else $error("enabled matrix flag without interrupt");

	a_one_row_low: assert property (@(posedge clk_i) disable iff (clr)
		$onehot0(~scan_output_pins_n_o))
		else $error("more than one scan output low");

	a_latch_point: assert property (@(posedge clk_i) disable iff (clr)
		latch |=> scan_counter == 8'h01 || !counter_run)
		else $error("latch outside pull-up end");

	a_clear_holds: assert property (@(posedge clk_i) disable iff (clr)
		act_ctrl[kscan_pkg::CTL_DATA_CLR] |=>
			scan_data[0] == kscan_pkg::SCAN_DATA_INIT && scan_data[7] == kscan_pkg::SCAN_DATA_INIT)
		else $error("data not held while clear bit set");

	a_stop_clears: assert property (@(posedge clk_i) disable iff (clr)
		!counter_run |=> scan_counter == 8'h00 && row == 3'h0)
		else $error("counter not cleared when stopped");

	a_sync_write: assert property (@(posedge clk_i) disable iff (clr)
		$changed(counter_run) |-> $past(op_tick))
		else $error("start bit took effect off the operating tick");

	a_wake_flag: assert property (@(posedge clk_i) disable iff (clr)
		soft_standby_i && scan_interrupt_o |=> standby_release_flag)
		else $error("standby release flag not set");

	a_low_window: assert property (@(posedge clk_i) disable iff (clr)
		!act_timing[kscan_pkg::TIM_LOW_LEN] && !duration && $stable(act_timing)
			|=> scan_output_pins_n_o == 8'hff)
		else $error("scan output low outside pull-up duration");

endmodule

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
	// crystal runs at 8 clocks a period to keep row periods short
	localparam int          XTAL    = 8;
	localparam logic [31:0] EN      = 32'h1 << kscan_pkg::CTL_FUNC_EN;
	localparam logic [31:0] S4      = 32'h1 << kscan_pkg::CTL_SIZE_4X4;
	localparam logic [31:0] CLR     = 32'h1 << kscan_pkg::CTL_DATA_CLR;
	localparam logic [31:0] MF      = 32'h1 << kscan_pkg::FLAG_MATRIX;
	localparam logic [7:0]  A_CTL   = kscan_pkg::OFS_CONTROL_1;
	localparam logic [7:0]  A_RUN   = kscan_pkg::OFS_COUNTER_START;
	localparam logic [7:0]  A_STAT  = kscan_pkg::OFS_SCAN_STATUS;
	localparam logic [7:0]  A_IEN   = kscan_pkg::OFS_IRQ_ENABLE;
	localparam logic [7:0]  A_DATA  = kscan_pkg::OFS_SCAN_DATA_0;
	localparam logic [7:0]  A_TIM   = kscan_pkg::OFS_COUNTER_TIME;

	logic        clk_i = 0;
	logic        rst_i = 1;
	logic        cyc_i = 0;
	logic        stb_i = 0;
	logic        we_i = 0;
	logic [7:0]  adr_i = '0;
	logic [3:0]  sel_i = '0;
	logic [31:0] dat_i = '0;
	logic [31:0] dat_o;
	logic [31:0] rdata;
	logic        ack_o;
	logic        module_stop_i = 0;
	logic        soft_standby_i = 0;
	logic        osc_enable_o;
	logic        wake_o;
	logic [1:0]  key_change_i = '0;
	logic        slow_crystal_input_i = 0;
	logic [7:0]  matrix_in_i;
	logic [7:0]  pullup_en_o;
	logic [7:0]  scan_output_pins_n_o;
	logic [7:0]  scan_output_pins_oe_o;
	logic        scan_interrupt_o;
	logic [63:0] keys = '0;
	int          miscompares = 0;
	int          num_checks = 0;
	int          cycles = 0;

	kscan_top DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.module_stop_i(module_stop_i), .soft_standby_i(soft_standby_i),
		.osc_enable_o(osc_enable_o), .wake_o(wake_o), .key_change_i(key_change_i),
		.slow_crystal_input_i(slow_crystal_input_i), .matrix_in_i(matrix_in_i),
		.pullup_en_o(pullup_en_o), .scan_output_pins_n_o(scan_output_pins_n_o),
		.scan_output_pins_oe_o(scan_output_pins_oe_o), .scan_interrupt_o(scan_interrupt_o));

	kscan_matrix_model MATRIX (.clk_i(clk_i), .keys_i(keys), .scan_n_i(scan_output_pins_n_o),
		.scan_oe_i(scan_output_pins_oe_o), .pullup_en_i(pullup_en_o), .matrix_o(matrix_in_i));

	// ------------------------------------------------------------
	// clocks, timeout and pin monitor
	// ------------------------------------------------------------
	initial
	begin
		forever #5 clk_i = ~clk_i;
	end

	// crystal offset from the clock edge so its sampling never races
	initial
	begin
		#3;
		forever #(XTAL*5) slow_crystal_input_i = ~slow_crystal_input_i;
	end

	// a hang ends the run through the same closing report
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 100000)
		begin
			miscompares++;
			summarize();
		end
	end

	always @(posedge clk_i)
		if (!rst_i && $countones(~scan_output_pins_n_o) > 1)
			check(32'($countones(~scan_output_pins_n_o)), 32'd1);

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	// classic single cycle; request held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= 4'hf;
		dat_i <= d;
		@(posedge clk_i);
		while (ack_o !== 1'b1 && n < 50)
		begin
			@(posedge clk_i);
			n++;
		end
		rdata = dat_o;
		check(32'(ack_o), 32'h1);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask

	task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		check(rdata, exp);
	endtask

	// control, pin, timing and start writes only land on an operating tick, so poll the read-back
	task automatic wait_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		int n;
		n = 0;
		do
		begin
			wb(1'b0, a, 32'h0);
			n++;
		end
		while ((rdata & m) !== exp && n < 8000);
		check(rdata & m, exp);
	endtask

	task automatic stop_counter;
		wb(1'b1, A_RUN, 32'h0);
		wait_reg(A_RUN, 32'h1, 32'h0);
	endtask

	task automatic measure(input logic [1:0] cks, input logic dbl, input logic lng);
		time t0;
		time t1;
		time t2;
		int  tick;
		int  per;
		tick = (2 << cks) * XTAL * 10;
		per = 128 * (dbl ? 2 : 1) * tick;
		stop_counter();
		wb(1'b1, A_TIM, 32'(cks) | (32'(dbl) << 4) | (32'(lng) << 5));
		wb(1'b1, A_RUN, 32'h1);
		@(negedge scan_output_pins_n_o[1]);
		t0 = $time;
		// in the long mode row 1 ends in the same step as row 2 begins
		fork
			begin
				@(posedge scan_output_pins_n_o[1]);
				t1 = $time;
			end
			begin
				@(negedge scan_output_pins_n_o[2]);
				t2 = $time;
			end
		join
		check(32'(t1 - t0), 32'(lng ? per : tick));
		check(32'(t2 - t0), 32'(per));
	endtask

	task automatic summarize;
		$display("checks %0d, mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		module_stop_i <= 1'b1;
		wb(1'b1, A_CTL, EN);
		check(osc_enable_o, 1'b0);
		expect_reg(A_DATA, 32'h0);
		module_stop_i <= 1'b0;
		expect_reg(A_CTL, 32'h0);
		for (int r = 0; r < 8; r++)
			expect_reg(A_DATA + 8'(4*r), 32'(kscan_pkg::SCAN_DATA_INIT));
		expect_reg(8'h40, 32'h0);
		expect_reg(A_STAT, 32'h0);
		$display("test standby and reset values done");

		// 4x4 key at row 2, column 1, chip asleep
		wb(1'b1, kscan_pkg::OFS_PIN_FUNCTION, 32'hffff);
		wb(1'b1, A_IEN, MF);
		wb(1'b1, A_CTL, EN | S4);
		keys[2*8+1] <= 1'b1;
		soft_standby_i <= 1'b1;
		wb(1'b1, A_RUN, 32'h1);
		wait_reg(A_STAT, MF, MF);
		check(scan_interrupt_o, 1'b1);
		check(wake_o, 1'b1);
		expect_reg(kscan_pkg::OFS_STANDBY_FLAGS, 32'h1);
		expect_reg(A_DATA + 8'd8, 32'hfd);
		expect_reg(A_DATA + 8'd16, 32'hff);
		soft_standby_i <= 1'b0;
		wb(1'b1, A_STAT, 32'h0);
		wait_reg(A_STAT, MF, 32'h0);
		check(scan_interrupt_o, 1'b0);
		// mask before the enable change, then the stored 0 turns to 1
		wb(1'b1, A_IEN, 32'h0);
		wait_reg(A_IEN, 32'h7, 32'h0);
		wb(1'b1, A_CTL, S4);
		wait_reg(A_STAT, MF, MF);
		check(scan_interrupt_o, 1'b0);
		check(32'(scan_output_pins_oe_o), 32'h0);
		expect_reg(A_DATA + 8'd8, 32'hff);
		wb(1'b1, A_IEN, MF);
		wait_reg(A_IEN, 32'h7, MF);
		check(scan_interrupt_o, 1'b1);
		wb(1'b1, A_STAT, 32'h0);
		stop_counter();
		expect_reg(kscan_pkg::OFS_SCAN_COUNTER, 32'h0);
		$display("test 4x4 key done");

		// 8x8 row 6: column 5 pressed, column 3 pressed but handed to another function
		keys <= '0;
		keys[6*8+5] <= 1'b1;
		keys[6*8+3] <= 1'b1;
		wb(1'b1, kscan_pkg::OFS_PIN_FUNCTION, 32'hfff7);
		wb(1'b1, A_CTL, EN);
		wait_reg(A_STAT, MF, 32'h0);
		wb(1'b1, A_RUN, 32'h1);
		wait_reg(A_STAT, MF, MF);
		// look inside a pull-up window, where selected columns are pulled
		@(posedge pullup_en_o[5]);
		check(32'(pullup_en_o), 32'hf7);
		expect_reg(A_DATA + 8'd24, 32'hdf);
		stop_counter();
		wb(1'b1, A_CTL, EN | CLR);
		wait_reg(A_CTL, CLR, CLR);
		wb(1'b1, A_CTL, EN);
		wait_reg(A_CTL, CLR, 32'h0);
		expect_reg(A_DATA + 8'd24, 32'hff);
		$display("test 8x8 and data clear done");

		// the two low-keys flags reach the same interrupt line
		wb(1'b1, A_STAT, 32'h0);
		wb(1'b1, A_IEN, 32'h3);
		key_change_i <= 2'b11;
		@(posedge clk_i);
		key_change_i <= 2'b00;
		wait_reg(A_STAT, 32'h3, 32'h3);
		check(scan_interrupt_o, 1'b1);
		$display("test key flags done");

		keys <= '0;
		wb(1'b1, A_CTL, EN | S4);
		measure(2'b01, 1'b0, 1'b0);
		measure(2'b00, 1'b1, 1'b1);
		$display("test timing done");
		summarize();
	end
endmodule
